/* rtl/fwd_defines.svh */
/*
 * Offsets, field positions, reset values for the video forwarding control.
 * Assumes inclusion by bare name from design files under rtl/.
 */
// What this block does
// - Port 1 is forwarded only while its disable bit (5, reset 1) is 0.
// - Port 0 is forwarded only while its disable bit (4, reset 1) is 0.
// - Replicate (bit 7, reset 0) makes output 1 carry output 0's data.
// - Sync forwarding waits until every enabled port has a line ready.
// - Send-when-ready (bit 6) lets each port's line go once it is ready.
// - Send-when-ready is ignored in concatenation and for short packets.
// - Sync field 3:2 (reset 00) decodes off, basic, interleave, concat.
// - Round robin (bit 0, reset 1) serves ready ports in turn, unsynced.
// - A status bit is 1 while synced video flows and 0 with sync off.
`ifndef FWD_DEFINES_SVH
`define FWD_DEFINES_SVH
// ----------------------------------------
// register byte addresses (index * 4)
// ----------------------------------------
`define FWD_IDX_PORT_DIS   8'h20
`define FWD_IDX_MODE_CTL   8'h21
`define FWD_IDX_STATUS     8'h22
`define FWD_ADDR_PORT_DIS  12'h080
`define FWD_ADDR_MODE_CTL  12'h084
`define FWD_ADDR_STATUS    12'h088
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define FWD_BIT_RX1_DIS    5
`define FWD_BIT_RX0_DIS    4
`define FWD_BIT_REPLICATE  7
`define FWD_BIT_WHEN_READY 6
`define FWD_SYNC_HI        3
`define FWD_SYNC_LO        2
`define FWD_BIT_RR         0
`define FWD_BIT_SYNCED     0
`define FWD_RST_PORT_DIS   8'h30
`define FWD_RST_MODE_CTL   8'h01
`define FWD_PORT_DIS_WMASK 8'hF0
`define FWD_MODE_WMASK     8'hCF
`endif

/* rtl/fwd_pkg.sv */
/*
 * Types shared by the forwarding control modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fwd_pkg;
	// synchronized forwarding field encoding
	typedef enum logic [1:0] {
		SYNC_OFF        = 2'h0,
		SYNC_BASIC      = 2'h1,
		SYNC_INTERLEAVE = 2'h2,
		SYNC_CONCAT     = 2'h3
	} sync_mode_t;
	// arbiter states
	typedef enum logic [1:0] {
		ARB_IDLE,
		ARB_SEND
	} arb_state_t;
endpackage : fwd_pkg

/* rtl/fwd_cfg_if.sv */
/*
 * Interface carrying decoded configuration from the register file to the
 * line arbiter. Assumes one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
interface fwd_cfg_if;
	import fwd_pkg::*;
	logic       [1:0] port_enable;
	logic             round_robin;
	sync_mode_t       sync_mode;
	logic             send_when_ready;
	logic             synced;
	modport regs (output port_enable, round_robin, sync_mode,
		send_when_ready, input synced);
	modport arb (input port_enable, round_robin, sync_mode,
		send_when_ready, output synced);
endinterface : fwd_cfg_if
`default_nettype wire

/* rtl/fwd_line_arbiter.sv */
/*
 * Line arbiter: picks which receive port's next packet goes to output 0.
 * Assumes the source holds line_ready until granted and that a grant
 * consumes one whole line or short packet.
 */
`timescale 1ns/10ps
`default_nettype none
module fwd_line_arbiter
	import fwd_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// configuration
	fwd_cfg_if.arb          cfg,
	// receive side requests
	input  wire logic [1:0] line_ready,
	input  wire logic [1:0] line_is_long,
	// grant out
	output var  logic [1:0] grant
);
	arb_state_t state;
	arb_state_t next_state;
	logic       last_port;
	logic [1:0] next_grant;

	// ----------------------------------------
	// request qualification
	// ----------------------------------------
	wire logic [1:0] req       = line_ready & cfg.port_enable;
	wire logic       sync_on   = (cfg.sync_mode != SYNC_OFF);
	wire logic       all_ready = (req == cfg.port_enable) &&
		(cfg.port_enable != 2'h0);
	// short packets always wait; concatenation ignores the relaxation
	wire logic [1:0] relax_ok  = (cfg.send_when_ready &&
		cfg.sync_mode != SYNC_CONCAT) ? (req & line_is_long) : 2'h0;
	wire logic [1:0] sync_req  = all_ready ? req : relax_ok;
	wire logic [1:0] eligible  = cfg.round_robin ? req :
		(sync_on ? sync_req : 2'h0);
	// rotating turn: prefer the port not served last
	wire logic       pick1     = eligible[1] &&
		(!eligible[0] || !last_port);
	wire logic [1:0] pick      = pick1 ? 2'h2 :
		(eligible[0] ? 2'h1 : 2'h0);

	// ----------------------------------------
	// grant sequencing: one-cycle grant, then one idle
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_grant = 2'h0;
		case (state)
			ARB_IDLE: begin
				if (pick != 2'h0) begin
					next_grant = pick;
					next_state = ARB_SEND;
				end
			end
			ARB_SEND: next_state = ARB_IDLE;
			default:  next_state = ARB_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= ARB_IDLE;
			grant     <= 2'h0;
			last_port <= 1'b0;
			cfg.synced <= 1'b0;
		end else begin
			state     <= next_state;
			grant     <= next_grant;
			if (next_grant != 2'h0)
				last_port <= next_grant[1];
			// synced only while sync mode runs and all enabled ports deliver
			cfg.synced <= sync_on && !cfg.round_robin && all_ready;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_no_disabled_grant;
		@(posedge pclk) disable iff (!presetn)
		(grant & ~$past(cfg.port_enable)) == 2'h0;
	endproperty
	a_no_disabled_grant: assert property (p_no_disabled_grant)
		else $error("grant to a disabled port");
	property p_sync_wait;
		@(posedge pclk) disable iff (!presetn)
		(state == ARB_IDLE && sync_on && !cfg.round_robin &&
		 !cfg.send_when_ready && !all_ready) |=> grant == 2'h0;
	endproperty
	a_sync_wait: assert property (p_sync_wait)
		else $error("sync grant before all ports ready");
	property p_when_ready;
		@(posedge pclk) disable iff (!presetn)
		(state == ARB_IDLE && sync_on && !cfg.round_robin &&
		 cfg.send_when_ready && cfg.sync_mode != SYNC_CONCAT &&
		 (req & line_is_long) != 2'h0) |=> grant != 2'h0;
	endproperty
	a_when_ready: assert property (p_when_ready)
		else $error("ready long line not sent");
	property p_concat_waits;
		@(posedge pclk) disable iff (!presetn)
		(cfg.sync_mode == SYNC_CONCAT && !cfg.round_robin && !all_ready)
		|=> grant == 2'h0;
	endproperty
	a_concat_waits: assert property (p_concat_waits)
		else $error("concat mode did not wait");
	property p_rr_serves;
		@(posedge pclk) disable iff (!presetn)
		(state == ARB_IDLE && cfg.round_robin && req != 2'h0)
		|=> grant != 2'h0 ##1 grant == 2'h0;
	endproperty
	a_rr_serves: assert property (p_rr_serves)
		else $error("round robin failed to serve");
	property p_rr_alternate;
		@(posedge pclk) disable iff (!presetn)
		(state == ARB_IDLE && cfg.round_robin && req == 2'h3 && last_port)
		|=> grant == 2'h1;
	endproperty
	a_rr_alternate: assert property (p_rr_alternate)
		else $error("round robin did not rotate");
	property p_off_no_grant;
		@(posedge pclk) disable iff (!presetn)
		(!cfg.round_robin && !sync_on) |=> grant == 2'h0;
	endproperty
	a_off_no_grant: assert property (p_off_no_grant)
		else $error("grant with forwarding off");
	c_rr_both: cover property (@(posedge pclk) disable iff (!presetn)
		cfg.round_robin && grant == 2'h1 ##2 grant == 2'h2);
	c_sync_grant: cover property (@(posedge pclk) disable iff (!presetn)
		!cfg.round_robin && sync_on && grant != 2'h0);
	c_synced: cover property (@(posedge pclk) disable iff (!presetn)
		cfg.synced);
endmodule : fwd_line_arbiter
`default_nettype wire

/* rtl/fwd_control.sv */
/*
 * Video forwarding control: APB register file for the port disable and
 * mode registers, a status register, the line arbiter, and the output 1
 * replicate path. Assumes a single pclk domain and an APB master.
 */
`timescale 1ns/10ps
`default_nettype none
`include "fwd_defines.svh"
module fwd_control
	import fwd_pkg::*;
#(
	parameter int DATA_W = 32
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	// receive side
	input  wire logic [1:0]        line_ready,
	input  wire logic [1:0]        line_is_long,
	input  wire logic [DATA_W-1:0] out0_data_in,
	// forwarding outputs
	output var  logic [1:0]        grant,
	output var  logic [DATA_W-1:0] out1_data,
	output var  logic              out1_active
);
	// a data path without bits cannot be built; refuse it while
	// elaborating rather than let a broken copy path through
	if (DATA_W < 1) begin : g_width_check
		$error("DATA_W must be positive");
	end

	logic [7:0] forward_port_disable;
	logic [7:0] forward_mode_control;
	fwd_cfg_if  cfg ();

	// ----------------------------------------
	// apb decode; answer in the access cycle, no wait states
	// ----------------------------------------
	wire logic hit_dis  = (paddr == `FWD_ADDR_PORT_DIS);
	wire logic hit_mode = (paddr == `FWD_ADDR_MODE_CTL);
	wire logic hit_sts  = (paddr == `FWD_ADDR_STATUS);
	wire logic mapped   = hit_dis | hit_mode | hit_sts;
	wire logic setup    = psel & !penable;
	wire logic wr_dis   = psel & penable & pwrite & hit_dis;
	wire logic wr_mode  = psel & penable & pwrite & hit_mode;
	// status is read-only; a write there is refused with an error
	wire logic bad      = !mapped || (pwrite && hit_sts);
	wire logic [7:0] rd_byte = hit_dis  ? forward_port_disable :
		hit_mode ? forward_mode_control :
		hit_sts  ? {7'h00, cfg.synced} : 8'h00;

	// ----------------------------------------
	// decoded configuration
	// ----------------------------------------
	assign cfg.port_enable = {
		!forward_port_disable[`FWD_BIT_RX1_DIS],
		!forward_port_disable[`FWD_BIT_RX0_DIS]};
	assign cfg.round_robin = forward_mode_control[`FWD_BIT_RR];
	// is on software; if both are set round robin wins
	assign cfg.sync_mode = sync_mode_t'(
		forward_mode_control[`FWD_SYNC_HI:`FWD_SYNC_LO]);
	assign cfg.send_when_ready =
		forward_mode_control[`FWD_BIT_WHEN_READY];

	// register writes; reserved bits 3:0 of disable and 5:4 of mode stay 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			forward_port_disable <= `FWD_RST_PORT_DIS;
			forward_mode_control <= `FWD_RST_MODE_CTL;
		end else begin
			if (wr_dis)
				forward_port_disable <= pwdata[7:0] & `FWD_PORT_DIS_WMASK;
			if (wr_mode)
				forward_mode_control <= pwdata[7:0] & `FWD_MODE_WMASK;
		end
	end

	// bus answer registered in the setup cycle, shown in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup & bad;
			prdata  <= (setup && !pwrite) ? {24'h00_0000, rd_byte} :
				32'h0000_0000;
		end
	end

	// ----------------------------------------
	// arbiter
	// ----------------------------------------
	fwd_line_arbiter u_arb (
		.pclk         (pclk),
		.presetn      (presetn),
		.cfg          (cfg.arb),
		.line_ready   (line_ready),
		.line_is_long (line_is_long),
		.grant        (grant)
	);

	// ----------------------------------------
	// replicate: output 1 mirrors output 0 word for word
	// ----------------------------------------
	// lane limit is software's; this path does not check lane count
	wire logic replicate = forward_mode_control[`FWD_BIT_REPLICATE];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out1_data   <= '0;
			out1_active <= 1'b0;
		end else begin
			out1_data   <= replicate ? out0_data_in : '0;
			out1_active <= replicate;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_replicate_copy;
		@(posedge pclk) disable iff (!presetn)
		replicate |=> out1_data == $past(out0_data_in);
	endproperty
	a_replicate_copy: assert property (p_replicate_copy)
		else $error("output 1 differs from output 0");
	property p_synced_off;
		@(posedge pclk) disable iff (!presetn)
		(cfg.sync_mode == SYNC_OFF) |=> !cfg.synced;
	endproperty
	a_synced_off: assert property (p_synced_off)
		else $error("synced flag with sync off");
	property p_pready_timing;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready;
	endproperty
	a_pready_timing: assert property (p_pready_timing)
		else $error("apb answer late");
	property p_disable_write;
		@(posedge pclk) disable iff (!presetn)
		wr_dis |=> forward_port_disable[`FWD_BIT_RX1_DIS] ==
			$past(pwdata[`FWD_BIT_RX1_DIS]) &&
			forward_port_disable[`FWD_BIT_RX0_DIS] ==
			$past(pwdata[`FWD_BIT_RX0_DIS]);
	endproperty
	a_disable_write: assert property (p_disable_write)
		else $error("disable bits not written");
	// a grant from port 1 needs its disable bit clear a cycle earlier
	property p_rx1_gated;
		@(posedge pclk) disable iff (!presetn)
		grant[1] |-> !$past(forward_port_disable[`FWD_BIT_RX1_DIS]);
	endproperty
	a_rx1_gated: assert property (p_rx1_gated)
		else $error("port 1 forwarded while disabled");
	// same gate for port 0
	property p_rx0_gated;
		@(posedge pclk) disable iff (!presetn)
		grant[0] |-> !$past(forward_port_disable[`FWD_BIT_RX0_DIS]);
	endproperty
	a_rx0_gated: assert property (p_rx0_gated)
		else $error("port 0 forwarded while disabled");
	// with replicate off output 1 stays quiet
	property p_replicate_off;
		@(posedge pclk) disable iff (!presetn)
		!replicate |=> out1_data == '0 && !out1_active;
	endproperty
	a_replicate_off: assert property (p_replicate_off)
		else $error("output 1 active without replicate");
	// sync field and round robin bit land as written
	property p_mode_write;
		@(posedge pclk) disable iff (!presetn)
		wr_mode |=> cfg.round_robin == $past(pwdata[`FWD_BIT_RR]) &&
			forward_mode_control[`FWD_SYNC_HI:`FWD_SYNC_LO] ==
			$past(pwdata[`FWD_SYNC_HI:`FWD_SYNC_LO]);
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("mode bits not written");

	// ----------------------------------------
	// bus protocol checks
	// ----------------------------------------
	// errors only ride on an answer
	property p_err_with_ready;
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready;
	endproperty
	a_err_with_ready: assert property (p_err_with_ready)
		else $error("error flag without ready");
	// read data is zero outside the access cycle
	property p_rdata_quiet;
		@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0000_0000;
	endproperty
	a_rdata_quiet: assert property (p_rdata_quiet)
		else $error("read data outside access cycle");
	// one answer per transfer: ready never stands two cycles
	property p_pready_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse)
		else $error("ready held past one cycle");
	// a write to status is refused and leaves the registers alone
	property p_sts_write_refused;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && hit_sts) |=>
			$stable(forward_port_disable) && $stable(forward_mode_control);
	endproperty
	a_sts_write_refused: assert property (p_sts_write_refused)
		else $error("status write changed a register");

	c_replicate: cover property (@(posedge pclk) disable iff (!presetn)
		replicate && out1_active);
	c_mode_write: cover property (@(posedge pclk) disable iff (!presetn)
		wr_mode);
endmodule : fwd_control
`default_nettype wire

/* testbench/rx_source.sv */
/*
 * Stand-in for the two receive ports: each holds one packet ready until
 * the block grants it. Assumes push pulses from the bench, one pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module rx_source (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// bench side
	input  wire logic [1:0] push,
	input  wire logic [1:0] push_long,
	// block side
	input  wire logic [1:0] grant,
	output var  logic [1:0] line_ready,
	output var  logic [1:0] line_is_long
);
	// ready holds until granted; kind flips once released so a stale
	// value is never mistaken for a live one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_ready   <= 2'h0;
			line_is_long <= 2'h0;
		end else begin
			for (int n = 0; n < 2; n++) begin
				if (push[n]) begin
					line_ready[n]   <= 1'b1;
					line_is_long[n] <= push_long[n];
				end else if (grant[n]) begin
					line_ready[n]   <= 1'b0;
					line_is_long[n] <= ~line_is_long[n];
				end
			end
		end
	end
endmodule : rx_source
`default_nettype wire

/* testbench/fwd_control_tb.sv */
/*
 * Self-checking bench for fwd_control: apb registers and forwarding.
 * Assumes rx_source stands in for the receive ports.
 */
`timescale 1ns/10ps
`default_nettype none
module fwd_control_tb;
	import fwd_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        err, out1_active;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, dd, out0_data_in, out1_data;
	logic [1:0]  line_ready, line_is_long, grant, push, push_long, seen;
	logic [1:0]  last = 2'h0;
	int          fail_count, n_tests, cyc, g0 = 0, g1 = 0, rr_bad = 0;
	fwd_control fwd_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.line_ready(line_ready), .line_is_long(line_is_long),
		.out0_data_in(out0_data_in), .grant(grant), .out1_data(out1_data),
		.out1_active(out1_active));
	rx_source rx_source_i (.pclk(pclk), .presetn(presetn), .push(push),
		.push_long(push_long), .grant(grant), .line_ready(line_ready),
		.line_is_long(line_is_long));
	// ----------------------------------------
	// clock, timeout, grant monitor
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// a grant to the same port while the other waits breaks the rotation
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (grant[0]) g0 <= g0 + 1;
		if (grant[1]) g1 <= g1 + 1;
		if (grant != 2'h0 && grant == last && (line_ready & ~grant) != 2'h0)
			rr_bad <= rr_bad + 1;
		if (grant != 2'h0) last <= grant;
		if (cyc == 5000) begin
			fail_count++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, dd, err);
	endtask : wr
	task pk(input logic [1:0] p, input logic [1:0] lg);
		@(posedge pclk);
		push      <= p;
		push_long <= lg;
		@(posedge pclk);
		push <= 2'h0;
	endtask : pk
	task watch(input int n);
		seen = 2'h0;
		repeat (n) begin
			@(posedge pclk);
			seen = seen | grant;
		end
	endtask : watch
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		apb(1'b0, 12'h080, 32'h0, rd, err);
		chk(rd, 32'h0000_0030);
		apb(1'b0, 12'h084, 32'h0, rd, err);
		chk(rd, 32'h0000_0001);
		apb(1'b0, 12'h08C, 32'h0, rd, err);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, 12'h088, 32'h1, rd, err);
		chk({31'h0, err}, 32'h1);
		pk(2'h3, 2'h3);
		watch(20);
		chk({30'h0, seen}, 32'h0);
	endtask : t_reset
	task t_rr;
		int a, b;
		a = g0;
		b = g1;
		wr(12'h080, 32'h0);
		repeat (3) begin
			watch(8);
			pk(2'h3, 2'h3);
		end
		watch(10);
		chk(g0 - a, 32'h4);
		chk(g1 - b, 32'h4);
		chk(rr_bad, 32'h0);
		wr(12'h080, 32'h20);
		pk(2'h3, 2'h3);
		watch(10);
		chk({30'h0, seen}, 32'h1);
		apb(1'b0, 12'h088, 32'h0, rd, err);
		chk(rd, 32'h0);
		wr(12'h080, 32'h0);
		watch(8);
		chk({30'h0, seen}, 32'h2);
		// port 1 went last, so port 0 must lead the next pair
		pk(2'h3, 2'h3);
		watch(2);
		chk({30'h0, seen}, 32'h1);
		watch(6);
	endtask : t_rr
	task t_sync;
		int gs;
		// both ports ready, yet nothing goes while every mode is off
		wr(12'h084, 32'h0);
		pk(2'h3, 2'h3);
		watch(10);
		chk({30'h0, seen}, 32'h0);
		apb(1'b0, 12'h088, 32'h0, rd, err);
		chk(rd, 32'h0);
		wr(12'h084, 32'h1);
		watch(8);
		for (int i = 1; i < 4; i++) begin
			wr(12'h084, {28'h0, i[1:0], 2'h0});
			pk(2'h1, 2'h1);
			watch(10);
			chk({30'h0, seen}, 32'h0);
			apb(1'b0, 12'h088, 32'h0, rd, err);
			chk(rd, 32'h0);
			gs = g0 + g1;
			pk(2'h2, 2'h3);
			apb(1'b0, 12'h088, 32'h0, rd, err);
			chk(rd, 32'h1);
			watch(6);
			// one line of the pair goes; the other waits for a new pair
			chk(g0 + g1 - gs, 32'h1);
			wr(12'h084, 32'h1);
			watch(8);
		end
	endtask : t_sync
	// short packets and concatenation ignore send-when-ready
	task t_swr;
		wr(12'h084, 32'h44);
		pk(2'h1, 2'h0);
		watch(10);
		chk({30'h0, seen}, 32'h0);
		wr(12'h084, 32'h1);
		watch(8);
		wr(12'h084, 32'h44);
		pk(2'h1, 2'h1);
		watch(10);
		chk({30'h0, seen}, 32'h1);
		wr(12'h084, 32'h4C);
		pk(2'h1, 2'h1);
		watch(10);
		chk({30'h0, seen}, 32'h0);
		wr(12'h084, 32'h1);
		watch(8);
	endtask : t_swr
	task t_rep;
		wr(12'h084, 32'h81); // lanes stay at two or fewer
		for (int i = 0; i < 3; i++) begin
			@(posedge pclk);
			out0_data_in <= 32'hA5C3_0F00 | i;
			repeat (2) @(posedge pclk);
			chk(out1_data, 32'hA5C3_0F00 | i);
			chk({31'h0, out1_active}, 32'h1);
		end
		wr(12'h084, 32'h1);
		repeat (2) @(posedge pclk);
		chk(out1_data, 32'h0);
		chk({31'h0, out1_active}, 32'h0);
	endtask : t_rep
	task end_of_test;
		if (fail_count == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, presetn} = 4'h0;
		paddr        = 12'h0;
		pwdata       = 32'h0;
		out0_data_in = 32'h0;
		push         = 2'h0;
		push_long    = 2'h0;
		{cyc, fail_count, n_tests} = 96'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rr();
		t_sync();
		t_swr();
		t_rep();
		end_of_test();
	end
endmodule : fwd_control_tb
`default_nettype wire
